// file: shared/gpeh_pkg.sv
package gpeh_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses.
  // ----------------------------------------------------------------------
  localparam logic [11:0] addr_port_e_direction      = 12'h000;
  localparam logic [11:0] addr_port_e_pin_levels     = 12'h004;
  localparam logic [11:0] addr_port_e_output_latch   = 12'h008;
  localparam logic [11:0] addr_port_h_direction      = 12'h00c;
  localparam logic [11:0] addr_port_h_pin_levels     = 12'h010;
  localparam logic [11:0] addr_port_h_output_latch   = 12'h014;
  localparam logic [11:0] addr_analog_ref_and_pin_config = 12'h018;
  localparam logic [11:0] addr_memory_control_register   = 12'h01c;
  localparam logic [11:0] addr_parallel_slave_control_register = 12'h020;
  localparam logic [11:0] addr_device_config         = 12'h024;

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int unsigned external_bus_disable_bit   = 7;
  localparam int unsigned parallel_slave_enable_bit  = 4;
  localparam int unsigned ccp2_pin_select_config_bit = 0;
  localparam int unsigned pwm_pin_map_select_config_bit = 1;
  localparam int unsigned microcontroller_mode_bit   = 2;
  localparam int unsigned pin80_device_bit           = 3;
  localparam int unsigned analog_cfg_width           = 4;
  localparam logic [7:0] rst_direction      = 8'hff;
  localparam logic [7:0] rst_latch          = 8'h00;
  localparam logic [7:0] rst_analog_config  = 8'h00;
  localparam logic [7:0] rst_memory_control = 8'h00;
  localparam logic [7:0] rst_psp_control    = 8'h00;
  localparam logic [7:0] rst_device_config  = 8'h0b;
  localparam logic [3:0] analog_all_digital = 4'hf;
  localparam logic [7:0] analog_cfg_write_mask    = 8'h3f;
  localparam logic [7:0] device_config_write_mask = 8'h0f;

  // ----------------------------------------------------------------------
  // Grouped signals.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpeh_pins_type;

  typedef struct packed {
    logic [7:0] e_dir;
    logic [7:0] e_lat;
    logic [7:0] h_dir;
    logic [7:0] h_lat;
    logic [7:0] adcfg;
    logic [7:0] memory_control_register;
    logic [7:0] parallel_slave_control_register;
    logic [7:0] devcfg;
    logic [7:0] e_sync1;
    logic [7:0] e_sync2;
    logic [7:0] h_sync1;
    logic [7:0] h_sync2;
    logic [31:0] prdata;
    logic       pready;
    logic       pslverr;
    gpeh_pins_type e_pins;
    gpeh_pins_type h_pins;
    logic [2:0] psp_ctrl;
    logic [3:0] analog_en;
  } gpeh_state_type;

endpackage : gpeh_pkg

// file: rtl/gpeh_port.sv
// Summary of operation
// [RULE_01] Port E: eight individually directed pins.
// [RULE_02] Port E direction one tri-states the pin.
// [RULE_03] Port E direction zero drives latch.
// [RULE_04] Latch reads return latch, not pins.
// [RULE_05] Reset makes all port E inputs. Code resets with the bus on, so port E oe follows ext_bus_ad_high_oe.
// [RULE_06] Pin seven carries CCP2 when selected.
// [RULE_07] Enabled bus drives AD15:8, overriding direction.
// [RULE_08] Port E usable only with bus disabled.
// [RULE_09] Slave enable turns pins 0-2 into controls.
// [RULE_10] Software keeps those direction bits set.
// [RULE_11] Port H direction selects drive or read.
// [RULE_12] Port H 0-3 carry address 16-19.
// [RULE_13] Port H 4-7 analog by default.
// [RULE_14] Port H 4-7 carry PWM outputs.
// [RULE_15] PWM mapping only when map bit clear.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module gpeh_port
  import gpeh_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [7:0]  port_e_in,
  output var  logic [7:0]  port_e_out,
  output var  logic [7:0]  port_e_oe,
  input  wire logic [7:0]  port_h_in,
  output var  logic [7:0]  port_h_out,
  output var  logic [7:0]  port_h_oe,
  input  wire logic [7:0]  ext_bus_ad_high,
  input  wire logic [7:0]  ext_bus_ad_high_oe,
  input  wire logic [3:0]  ext_address_line_16_to_19,
  input  wire logic        enhanced_ccp_module_two_out,
  input  wire logic        enhanced_ccp_module_two_oe,
  input  wire logic        pwm3_channel_c,
  input  wire logic        pwm3_channel_b,
  input  wire logic        pwm1_channel_c,
  input  wire logic        pwm1_channel_b,
  input  wire logic [3:0]  pwm_tristate,
  output var  logic [2:0]  parallel_slave_controls,
  output var  logic [3:0]  analog_channel_12_to_15_en
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  gpeh_state_type state;
  gpeh_state_type next_state;

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  function automatic logic [7:0] lane_write(input logic [7:0] old_value,
                                            input logic [31:0] wdata,
                                            input logic [3:0] strb);
    if (strb[0])
    begin
      lane_write = wdata[7:0];
    end
    else
    begin
      lane_write = old_value;
    end
  endfunction

  function automatic logic [7:0] port_read(input logic [7:0] levels,
                                           input logic [7:0] keep);
    port_read = levels & keep;
  endfunction

  function automatic logic [3:0] analog_pins(input logic [7:0] dir,
                                             input logic [7:0] cfg);
    if (cfg[analog_cfg_width-1:0] == analog_all_digital)
    begin
      analog_pins = 4'h0;
    end
    else
    begin
      analog_pins = dir[7:4];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Decoded modes and pin drive.
  // ----------------------------------------------------------------------
  logic        access;
  logic        first_beat;
  logic        wr;
  logic        bus_on;
  logic        micro_mode;
  logic        ccp2_alt;
  logic        slave_on;
  logic        pwm_map;
  logic [3:0]  pwm_val;
  logic [7:0]  e_mask;
  logic [7:0]  e_out;
  logic [7:0]  e_oe;
  logic [7:0]  h_out;
  logic [7:0]  h_oe;
  logic [31:0] rd;
  logic        err;

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    access = psel & penable;
    first_beat = access & ~state.pready;
    wr = first_beat & pwrite;
    rd = 32'h0000_0000;
    err = 1'b0;

    // ----------------------------------------------------------------------
    // Pin synchronisers.
    // ----------------------------------------------------------------------
    next_state.e_sync1 = port_e_in;
    next_state.e_sync2 = state.e_sync1;
    next_state.h_sync1 = port_h_in;
    next_state.h_sync2 = state.h_sync1;

    // ----------------------------------------------------------------------
    // Mode decode.
    // ----------------------------------------------------------------------
    bus_on = state.devcfg[pin80_device_bit] & ~state.memory_control_register[external_bus_disable_bit];
    micro_mode = state.devcfg[microcontroller_mode_bit];
    ccp2_alt = micro_mode & ~state.devcfg[ccp2_pin_select_config_bit];
    slave_on = state.parallel_slave_control_register[parallel_slave_enable_bit] & ~bus_on; // [RULE_08]
    pwm_map = ~state.devcfg[pwm_pin_map_select_config_bit];
    pwm_val = {pwm1_channel_b, pwm1_channel_c, pwm3_channel_b, pwm3_channel_c};

    // ----------------------------------------------------------------------
    // Port E drive.
    // ----------------------------------------------------------------------
    e_mask = 8'hff;
    if (slave_on)
    begin
      e_mask[2:0] = 3'h0; // [RULE_09]
    end
    e_out = state.e_lat; // [RULE_03]
    e_oe = ~state.e_dir & e_mask; // [RULE_01] [RULE_02]
    if (ccp2_alt)
    begin
      e_out[7] = enhanced_ccp_module_two_out; // [RULE_06]
      e_oe[7] = enhanced_ccp_module_two_oe & ~state.e_dir[7];
    end
    if (bus_on)
    begin
      e_out = ext_bus_ad_high; // [RULE_07] [RULE_08]
      e_oe = ext_bus_ad_high_oe;
    end
    next_state.e_pins.out = e_out;
    next_state.e_pins.oe = e_oe;
    next_state.psp_ctrl = slave_on ? state.e_sync2[2:0] : 3'h0; // [RULE_09]

    // ----------------------------------------------------------------------
    // Port H drive.
    // ----------------------------------------------------------------------
    h_out = state.h_lat;
    h_oe = ~state.h_dir; // [RULE_11]
    if (bus_on)
    begin
      h_out[3:0] = ext_address_line_16_to_19; // [RULE_12]
      h_oe[3:0] = 4'hf;
    end
    if (pwm_map)
    begin
      h_out[7:4] = pwm_val; // [RULE_14] [RULE_15]
      h_oe[7:4] = ~state.h_dir[7:4] & ~pwm_tristate;
    end
    next_state.h_pins.out = h_out;
    next_state.h_pins.oe = h_oe;
    next_state.analog_en = analog_pins(state.h_dir, state.adcfg); // [RULE_13]

    // ----------------------------------------------------------------------
    // Register access.
    // ----------------------------------------------------------------------
    case (paddr)
      addr_port_e_direction:
      begin
        rd[7:0] = state.e_dir;
        if (wr)
        begin
          next_state.e_dir = lane_write(state.e_dir, pwdata, pstrb);
        end
      end

      addr_port_e_pin_levels:
      begin
        rd[7:0] = port_read(state.e_sync2, e_mask);
        if (wr)
        begin
          next_state.e_lat = lane_write(state.e_lat, pwdata, pstrb);
        end
      end

      addr_port_e_output_latch:
      begin
        rd[7:0] = state.e_lat; // [RULE_04]
        if (wr)
        begin
          next_state.e_lat = lane_write(state.e_lat, pwdata, pstrb); // [RULE_04]
        end
      end

      addr_port_h_direction:
      begin
        rd[7:0] = state.h_dir;
        if (wr)
        begin
          next_state.h_dir = lane_write(state.h_dir, pwdata, pstrb);
        end
      end

      addr_port_h_pin_levels:
      begin
        rd[7:0] = port_read(state.h_sync2, ~{state.analog_en, 4'h0}); // [RULE_11]
        if (wr)
        begin
          next_state.h_lat = lane_write(state.h_lat, pwdata, pstrb);
        end
      end

      addr_port_h_output_latch:
      begin
        rd[7:0] = state.h_lat;
        if (wr)
        begin
          next_state.h_lat = lane_write(state.h_lat, pwdata, pstrb);
        end
      end

      addr_analog_ref_and_pin_config:
      begin
        rd[7:0] = state.adcfg & analog_cfg_write_mask;
        if (wr)
        begin
          next_state.adcfg = lane_write(state.adcfg, pwdata, pstrb) & analog_cfg_write_mask;
        end
      end

      addr_memory_control_register:
      begin
        rd[7:0] = state.memory_control_register;
        if (wr)
        begin
          next_state.memory_control_register = lane_write(state.memory_control_register, pwdata, pstrb);
        end
      end

      addr_parallel_slave_control_register:
      begin
        rd[7:0] = state.parallel_slave_control_register;
        if (wr)
        begin
          next_state.parallel_slave_control_register = lane_write(state.parallel_slave_control_register, pwdata, pstrb);
        end
      end

      addr_device_config:
      begin
        rd[7:0] = state.devcfg & device_config_write_mask;
        if (wr)
        begin
          next_state.devcfg = lane_write(state.devcfg, pwdata, pstrb) & device_config_write_mask;
        end
      end

      default:
      begin
        err = 1'b1;
      end
    endcase

    // ----------------------------------------------------------------------
    // Bus answer.
    // ----------------------------------------------------------------------
    next_state.pready = first_beat;
    next_state.pslverr = first_beat & err;
    next_state.prdata = 32'h0000_0000;
    if (first_beat & ~pwrite)
    begin
      next_state.prdata = rd;
    end
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state.e_sync1 <= '0;
      state.e_sync2 <= '0;
      state.h_sync1 <= '0;
      state.h_sync2 <= '0;
      state.prdata <= '0;
      state.pready <= '0;
      state.pslverr <= '0;
      state.e_pins <= '0;
      state.h_pins <= '0;
      state.psp_ctrl <= '0;
      state.analog_en <= '0;
      state.e_dir <= rst_direction; // [RULE_05]
      state.h_dir <= rst_direction; // [RULE_13]
      state.e_lat <= rst_latch;
      state.h_lat <= rst_latch;
      state.adcfg <= rst_analog_config;
      state.memory_control_register <= rst_memory_control;
      state.parallel_slave_control_register <= rst_psp_control;
      state.devcfg <= rst_device_config;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign port_e_out = state.e_pins.out;
  assign port_e_oe = state.e_pins.oe;
  assign port_h_out = state.h_pins.out;
  assign port_h_oe = state.h_pins.oe;
  assign parallel_slave_controls = state.psp_ctrl;
  assign analog_channel_12_to_15_en = state.analog_en;

  logic unused_ok;
  assign unused_ok = &{1'b0, pwdata[31:8], pstrb[3:1]};

endmodule : gpeh_port
`default_nettype wire

// file: test/gpeh_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpeh_pin_model
(
  input  wire logic [7:0] drv,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] ext,
  output var  logic [7:0] pin
);
  // ----------
  // Pad wire.
  // ----------
  // Driven bits show the port, released bits the outside driver.
  assign pin = (drv & oe) | (ext & ~oe);
endmodule // gpeh_pin_model
`default_nettype wire

// file: test/gpeh_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module gpeh_port_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  port_e_oe,
  input wire logic [7:0]  port_h_oe,
  input wire logic [2:0]  parallel_slave_controls,
  input wire logic [3:0]  analog_channel_12_to_15_en
);
  // ---------
  // Checks.
  // ---------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  ready_pulse_a: assert property (s_take |=> s_answer)
    else $error("Ready missing or too long.");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("Error without ready.");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("Read data outside a read answer.");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("Upper read bits set.");
  reset_inputs_a: assert property ($rose(presetn) |-> port_e_oe == 8'h0 && port_h_oe == 8'h0)
    else $error("Pin driven out of reset.");
  analog_default_a: assert property ($rose(presetn) |=> analog_channel_12_to_15_en == 4'hf)
    else $error("Analog default missing.");
  analog_nodrive_a: assert property ((analog_channel_12_to_15_en & port_h_oe[7:4]) == 4'h0)
    else $error("Analog pin driven.");
  slave_mask_a: assert property (parallel_slave_controls != 3'h0 |-> port_e_oe[2:0] == 3'h0)
    else $error("Slave control pin driven.");
endmodule // gpeh_port_monitor
bind gpeh_port gpeh_port_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .port_e_oe, .port_h_oe, .parallel_slave_controls, .analog_channel_12_to_15_en);
`default_nettype wire

// file: test/gpeh_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h seen %h", n, e, s); end end
module gpeh_port_tb;
  import gpeh_pkg::*;
  // ---------
  // Bench.
  // ---------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic        enhanced_ccp_module_two_out = 0, enhanced_ccp_module_two_oe = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'hf, ext_address_line_16_to_19 = 0, pwm_tristate = 0, pw = 0;
  logic [3:0]  analog_channel_12_to_15_en;
  logic [7:0]  port_e_in, port_e_out, port_e_oe, port_h_in, port_h_out, port_h_oe, r, d, x;
  logic [7:0]  e_ext = 0, h_ext = 0, ext_bus_ad_high = 0, ext_bus_ad_high_oe = 0;
  logic [2:0]  parallel_slave_controls;
  logic [32:0] q[$], nt;
  int          miscompares = 0, check_count = 0;
  logic [11:0] ra[7] = '{addr_port_e_direction, addr_port_e_output_latch, addr_port_h_direction,
    addr_port_h_output_latch, addr_analog_ref_and_pin_config, addr_memory_control_register, addr_device_config};
  logic [7:0]  rv[7] = '{rst_direction, rst_latch, rst_direction, rst_latch, rst_analog_config,
    rst_memory_control, rst_device_config};
  always #5 pclk = ~pclk;
  gpeh_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .port_e_in, .port_e_out, .port_e_oe, .port_h_in, .port_h_out, .port_h_oe, .ext_bus_ad_high,
    .ext_bus_ad_high_oe, .ext_address_line_16_to_19, .enhanced_ccp_module_two_out, .enhanced_ccp_module_two_oe,
    .pwm3_channel_c(pw[0]), .pwm3_channel_b(pw[1]), .pwm1_channel_c(pw[2]), .pwm1_channel_b(pw[3]),
    .pwm_tristate, .parallel_slave_controls, .analog_channel_12_to_15_en);
  gpeh_pin_model i_pe (.drv(port_e_out), .oe(port_e_oe), .ext(e_ext), .pin(port_e_in));
  gpeh_pin_model i_ph (.drv(port_h_out), .oe(port_h_oe), .ext(h_ext), .pin(port_h_in));
  task automatic results;
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v, input logic [32:0] e);
    int n;
    n = 0;
    q.push_back(e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, 24'h0, v};
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    {psel, penable} <= 2'h0;
    if (n == 20)
    begin
      miscompares++;
      results;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'h1, a, v, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] v);
    apb(1'h0, a, 8'h0, {25'h0, v});
  endtask
  always @(negedge pclk)
    if (pready === 1'h1)
    begin
      nt = q.pop_front();
      `CHK("apb answer", nt, {pslverr, prdata})
    end
  initial
  begin
    repeat (50000) @(posedge pclk);
    miscompares++;
    results;
  end
  initial
  begin
    r = $urandom(32582);
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    apb(1'h0, 12'h028, 8'h0, {1'h1, 32'h0});
    wr(addr_analog_ref_and_pin_config, {4'h0, analog_all_digital});
    wr(addr_memory_control_register, 8'h80);
    `CHK("analog", 4'h0, analog_channel_12_to_15_en)
    repeat (4)
    begin
      {r, d, x} = 24'($urandom);
      {e_ext, h_ext} <= {x, ~x};
      wr(addr_port_e_pin_levels, r);
      wr(addr_port_e_direction, d);
      wr(addr_port_h_output_latch, ~r);
      wr(addr_port_h_direction, ~d);
      repeat (3) @(posedge pclk);
      `CHK("e oe", ~d, port_e_oe)
      `CHK("e out", r & ~d, port_e_out & ~d)
      `CHK("h drive", {d, ~r & d}, {port_h_oe, port_h_out & d})
      rd(addr_port_e_output_latch, r);
      rd(addr_port_e_pin_levels, (r & ~d) | (x & d));
      rd(addr_port_h_pin_levels, (~r & d) | (~x & ~d));
    end
    {ext_bus_ad_high, ext_bus_ad_high_oe, ext_address_line_16_to_19} <= {x, r, x[7:4]};
    wr(addr_memory_control_register, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("bus", {r, x & r}, {port_e_oe, port_e_out & r})
    `CHK("addr", {4'hf, x[7:4]}, {port_h_oe[3:0], port_h_out[3:0]})
    wr(addr_memory_control_register, 8'h80);
    {pw, pwm_tristate} <= {x[3:0], r[3:0]};
    wr(addr_device_config, 8'h09);
    wr(addr_port_h_direction, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("pwm oe", ~r[3:0], port_h_oe[7:4])
    `CHK("pwm out", x[3:0] & ~r[3:0], port_h_out[7:4] & ~r[3:0])
    {enhanced_ccp_module_two_oe, enhanced_ccp_module_two_out} <= {1'h1, x[0]};
    wr(addr_device_config, 8'h0e);
    wr(addr_port_e_direction, 8'h7f);
    repeat (2) @(posedge pclk);
    `CHK("e7", {1'h1, x[0]}, {port_e_oe[7], port_e_out[7]})
    e_ext <= {x[7:3], 3'h5};
    wr(addr_device_config, rst_device_config);
    wr(addr_parallel_slave_control_register, 8'h10);
    wr(addr_port_e_direction, 8'h07);
    repeat (4) @(posedge pclk);
    `CHK("slave", {3'h5, 8'hf8}, {parallel_slave_controls, port_e_oe})
    rd(addr_port_e_pin_levels, {r[7:3], 3'h0});
    wr(addr_memory_control_register, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("slave off", 3'h0, parallel_slave_controls)
    wr(addr_memory_control_register, 8'h80);
    wr(addr_analog_ref_and_pin_config, 8'h00);
    wr(addr_port_h_direction, 8'hf0);
    repeat (2) @(posedge pclk);
    `CHK("analog", 4'hf, analog_channel_12_to_15_en)
    results;
  end
endmodule // gpeh_port_tb
`default_nettype wire
